// ==== design/tch_pkg.sv ====
// Constants for the teleprinter character handler: register map, fields, codes, timing.
// Assumes a 200 MHz system clock and an AXI4-Lite register bus with 32-bit data.
package tch_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] FORM_LEN_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] AB_WRITE_OFF = 8'h0C;
  localparam logic [7:0] AB_LEN_OFF = 8'h10;
  // Control register fields
  localparam int CTRL_PARITY_EN = 0;
  localparam int CTRL_PARITY_FITTED = 1;
  localparam int CTRL_FIXED_LEVEL = 2;
  localparam int CTRL_DOUBLE_LF = 3;
  localparam int CTRL_AUTO_RETURN = 4;
  localparam int CTRL_BELL_EN = 5;
  localparam int CTRL_READER_AUTO = 6;
  localparam int CTRL_AB_FITTED = 7;
  localparam int CTRL_EOT_FITTED = 8;
  localparam int CTRL_SPROCKET = 9;
  localparam int CTRL_DATASET = 10;
  localparam int CTRL_W = 11;
  localparam logic [10:0] CTRL_RST = 11'h7F3;
  localparam logic [7:0] FORM_LEN_RST = 8'h42;
  localparam logic [4:0] AB_LEN_RST = 5'h00;
  // Answer-back write register fields
  localparam int AB_IDX_LSB = 8;
  localparam int AB_IDX_W = 5;
  // Character codes
  localparam logic [6:0] C_NUL = 7'h00;
  localparam logic [6:0] C_EOT = 7'h04;
  localparam logic [6:0] C_ENQ = 7'h05;
  localparam logic [6:0] C_LF = 7'h0A;
  localparam logic [6:0] C_FF = 7'h0C;
  localparam logic [6:0] C_CR = 7'h0D;
  localparam logic [6:0] C_DC1 = 7'h11;
  localparam logic [6:0] C_DC3 = 7'h13;
  localparam logic [6:0] C_SP = 7'h20;
  localparam logic [6:0] C_DEL = 7'h7F;
  // Line and timing
  localparam int LINE_LEN = 72;
  localparam int BELL_POS = 71;
  localparam int AB_MAX = 20;
  localparam int CLK_PERIOD_NS = 5;
  localparam int BIT_TIME_NS = 9090909;
  localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SEND = 2'b10} tch_tx_t;
endpackage

// ==== design/tch_top.sv ====
// Teleprinter character handler: keyboard/tape transmit, printer decode, alarms, registers.
// Assumes all inputs synchronous to clk; register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module tch_top #(
  parameter int BIT_CYCLES = tch_pkg::BIT_CYCLES,
  parameter int LINE_LEN = tch_pkg::LINE_LEN
) (
  input wire logic clk, // 200 MHz clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic kb_key_down, // A key is held
  input wire logic [6:0] kb_code, // Code of held key
  input wire logic kb_repeat, // Repeat key held
  input wire logic kb_break, // Break key held
  input wire logic kb_eot, // End-of-transmission key
  input wire logic ab_trigger, // Local answer-back trigger
  input wire logic tape_valid, // Tape reader cycle done
  input wire logic [7:0] tape_holes, // 1 = hole sensed
  input wire logic rx_valid, // Received character strobe
  input wire logic [7:0] rx_code, // Received character
  input wire logic forms_out, // Sprocket forms exhausted
  input wire logic low_paper, // Friction roll low switch
  output logic line_out, // Serial line, 1 = mark
  output logic tape_ready, // Reader cycle may be taken
  output logic reader_run, // Reader started
  output logic print_strobe, // Print a glyph
  output logic [6:0] print_glyph, // Glyph to print
  output logic cr_pulse, // Return to margin
  output logic feed_pulse, // Advance paper
  output logic [7:0] feed_lines, // Lines for feed_pulse
  output logic space_pulse, // Move right without print
  output logic line_end_bell, // End-of-line bell pulse
  output logic paper_alarm, // Forms-out alarm
  output logic refuse_calls, // Refuse incoming calls
  output logic low_supply_alarm // Low paper alarm
);
  import tch_pkg::*;

  logic [CTRL_W-1:0] ctrl_reg;
  logic [7:0] form_len_reg;
  logic [4:0] ab_len_reg;
  logic [6:0] ab_mem [AB_MAX];
  logic [7:0] aw_addr_reg, ar_addr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [6:0] col_reg;
  tch_tx_t tx_state_reg;
  logic [10:0] tx_shift_reg;
  logic [3:0] bit_cnt_reg;
  logic [31:0] baud_cnt_reg;
  logic [7:0] tx_code_reg;
  logic tx_from_kb_reg, echo_reg, kb_down_q, eot_q, ab_trig_q, eot_pend_reg;
  logic ab_active_reg;
  logic [4:0] ab_idx_reg;

  // Eighth level: even parity, fixed level, or mark when not fitted
  function automatic logic [7:0] with_level8(input logic [6:0] c, input logic [CTRL_W-1:0] cr);
    logic p;
    p = 1'b1;
    if (cr[CTRL_PARITY_FITTED]) begin
      p = cr[CTRL_PARITY_EN] ? ^c : cr[CTRL_FIXED_LEVEL];
    end
    return {p, c};
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  logic aw_held, w_held, do_write, wr_ok, rd_ok;
  logic [31:0] status_w, ctrl_m, form_m, ab_m;
  assign aw_held = ~s_axi_awready;
  assign w_held = ~s_axi_wready;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign wr_ok = (aw_addr_reg == CTRL_OFF) | (aw_addr_reg == FORM_LEN_OFF)
               | (aw_addr_reg == AB_WRITE_OFF) | (aw_addr_reg == AB_LEN_OFF);
  assign rd_ok = (ar_addr_reg == CTRL_OFF) | (ar_addr_reg == FORM_LEN_OFF)
               | (ar_addr_reg == STATUS_OFF) | (ar_addr_reg == AB_LEN_OFF);
  assign ctrl_m = merge({21'h0, ctrl_reg}, wdata_reg, wstrb_reg);
  assign form_m = merge({24'h0, form_len_reg}, wdata_reg, wstrb_reg);
  assign ab_m = merge(32'h0, wdata_reg, wstrb_reg);
  assign status_w = {19'h0, tx_state_reg == TX_SEND, kb_break, low_supply_alarm,
                     refuse_calls, paper_alarm, reader_run, col_reg};

  // Write channel handshake: address and data in either order, response after both
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RST;
      form_len_reg <= FORM_LEN_RST;
      ab_len_reg <= AB_LEN_RST;
    end else if (do_write) begin
      if (aw_addr_reg == CTRL_OFF) begin
        ctrl_reg <= ctrl_m[CTRL_W-1:0];
      end
      if (aw_addr_reg == FORM_LEN_OFF) begin
        form_len_reg <= form_m[7:0];
      end
      if (aw_addr_reg == AB_LEN_OFF && wstrb_reg[0]) begin
        ab_len_reg <= (wdata_reg[4:0] > 5'(AB_MAX)) ? 5'(AB_MAX) : wdata_reg[4:0];
      end
    end
  end

  // Answer-back character store, no reset
  always_ff @(posedge clk) begin
    if (do_write && aw_addr_reg == AB_WRITE_OFF
        && ab_m[AB_IDX_LSB +: AB_IDX_W] < 5'(AB_MAX)) begin
      ab_mem[ab_m[AB_IDX_LSB +: AB_IDX_W]] <= ab_m[6:0];
    end
  end

  // Read channel: data one cycle after the address is taken
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
      ar_addr_reg <= 8'h00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        ar_addr_reg <= s_axi_araddr;
      end
      if (!s_axi_arready && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        case (ar_addr_reg)
          CTRL_OFF: s_axi_rdata <= {21'h0, ctrl_reg};
          FORM_LEN_OFF: s_axi_rdata <= {24'h0, form_len_reg};
          STATUS_OFF: s_axi_rdata <= status_w;
          AB_LEN_OFF: s_axi_rdata <= {27'h0, ab_len_reg};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Source selection for the next frame
  logic kb_new, kb_rep, rx_enq, tape_take, can_start;
  assign rx_enq = rx_valid && rx_code[6:0] == C_ENQ && ctrl_reg[CTRL_AB_FITTED];
  assign can_start = tx_state_reg == TX_IDLE && !kb_break;
  assign kb_new = kb_key_down && !kb_down_q;
  assign kb_rep = kb_key_down && kb_repeat;
  assign tape_take = tape_valid && tape_ready;

  // Key edges, answer-back and end-of-transmission requests
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      kb_down_q <= 1'b0;
      eot_q <= 1'b0;
      ab_trig_q <= 1'b0;
      eot_pend_reg <= 1'b0;
      ab_active_reg <= 1'b0;
      ab_idx_reg <= 5'h00;
    end else begin
      kb_down_q <= kb_key_down;
      eot_q <= kb_eot;
      ab_trig_q <= ab_trigger;
      if (kb_eot && !eot_q && ctrl_reg[CTRL_EOT_FITTED]) begin
        eot_pend_reg <= 1'b1;
      end else if (can_start && eot_pend_reg && !ab_active_reg) begin
        eot_pend_reg <= 1'b0;
      end
      if (!ab_active_reg && ab_len_reg != 5'h00
          && ((ab_trigger && !ab_trig_q && ctrl_reg[CTRL_AB_FITTED]) || rx_enq)) begin
        ab_active_reg <= 1'b1;
        ab_idx_reg <= 5'h00;
      end else if (ab_active_reg && can_start) begin
        ab_idx_reg <= ab_idx_reg + 5'h01;
        if (ab_idx_reg + 5'h01 >= ab_len_reg) begin
          ab_active_reg <= 1'b0;
        end
      end
    end
  end

  // Serializer: start space, eight levels, two stop marks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 11'h7FF;
      bit_cnt_reg <= 4'h0;
      baud_cnt_reg <= 32'h0;
      tx_code_reg <= 8'h00;
      tx_from_kb_reg <= 1'b0;
      echo_reg <= 1'b0;
      line_out <= 1'b1;
      tape_ready <= 1'b0;
    end else begin
      echo_reg <= 1'b0;
      tape_ready <= can_start && reader_run && !ab_active_reg && !eot_pend_reg
                    && !tape_take;
      case (tx_state_reg)
        TX_IDLE: begin
          line_out <= !kb_break;
          if (can_start && (ab_active_reg || eot_pend_reg || tape_take || kb_new || kb_rep)) begin
            logic [7:0] c;
            c = with_level8(kb_code, ctrl_reg);
            tx_from_kb_reg <= 1'b0;
            if (ab_active_reg) begin
              c = with_level8(ab_mem[ab_idx_reg], ctrl_reg);
            end else if (eot_pend_reg) begin
              c = with_level8(C_EOT, ctrl_reg);
            end else if (tape_take) begin
              c = tape_holes;
            end else begin
              tx_from_kb_reg <= 1'b1;
            end
            tx_code_reg <= c;
            tx_shift_reg <= {2'b11, c, 1'b0};
            bit_cnt_reg <= 4'h0;
            baud_cnt_reg <= 32'h0;
            tx_state_reg <= TX_SEND;
          end
        end
        TX_SEND: begin
          line_out <= tx_shift_reg[0] && !kb_break;
          if (baud_cnt_reg == 32'(BIT_CYCLES - 1)) begin
            baud_cnt_reg <= 32'h0;
            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'hA) begin
              tx_state_reg <= TX_IDLE;
              echo_reg <= 1'b1;
            end
          end else begin
            baud_cnt_reg <= baud_cnt_reg + 32'h1;
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // Printer input: received code wins over local echo
  logic pv, is_print, is_func;
  logic [6:0] pc;
  assign pv = rx_valid | echo_reg;
  assign pc = rx_valid ? rx_code[6:0] : tx_code_reg[6:0];
  assign is_print = pc > C_SP && pc < C_DEL;
  assign is_func = !is_print && pc != C_SP;

  // Printer decode and column tracking
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      col_reg <= 7'h00;
      print_strobe <= 1'b0;
      print_glyph <= 7'h00;
      cr_pulse <= 1'b0;
      feed_pulse <= 1'b0;
      feed_lines <= 8'h00;
      space_pulse <= 1'b0;
      line_end_bell <= 1'b0;
    end else begin
      print_strobe <= 1'b0;
      cr_pulse <= 1'b0;
      feed_pulse <= 1'b0;
      space_pulse <= 1'b0;
      line_end_bell <= 1'b0;
      if (pv) begin
        if (is_print) begin
          print_strobe <= 1'b1;
          print_glyph <= pc;
          if (col_reg < 7'(LINE_LEN)) begin
            col_reg <= col_reg + 7'h01;
          end
          if (col_reg == 7'(BELL_POS - 1) && ctrl_reg[CTRL_BELL_EN]) begin
            line_end_bell <= 1'b1;
          end
          if (col_reg == 7'(LINE_LEN - 1) && ctrl_reg[CTRL_AUTO_RETURN]) begin
            col_reg <= 7'h00;
            cr_pulse <= 1'b1;
            feed_pulse <= 1'b1;
            feed_lines <= 8'h01;
          end
        end else if (pc == C_SP) begin
          if (col_reg < 7'(LINE_LEN)) begin
            col_reg <= col_reg + 7'h01;
            space_pulse <= 1'b1;
          end
        end else if (pc == C_CR) begin
          col_reg <= 7'h00;
          cr_pulse <= 1'b1;
        end else if (pc == C_LF) begin
          feed_pulse <= 1'b1;
          feed_lines <= ctrl_reg[CTRL_DOUBLE_LF] ? 8'h02 : 8'h01;
        end else if (pc == C_FF && ctrl_reg[CTRL_SPROCKET]) begin
          feed_pulse <= 1'b1;
          feed_lines <= form_len_reg;
        end
      end
    end
  end

  // Reader control and paper alarms
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reader_run <= 1'b0;
      paper_alarm <= 1'b0;
      refuse_calls <= 1'b0;
      low_supply_alarm <= 1'b0;
    end else begin
      if (pv && ctrl_reg[CTRL_READER_AUTO] && pc == C_DC1) begin
        reader_run <= 1'b1;
      end else if (pv && ctrl_reg[CTRL_READER_AUTO] && pc == C_DC3) begin
        reader_run <= 1'b0;
      end
      paper_alarm <= forms_out && ctrl_reg[CTRL_SPROCKET] && ctrl_reg[CTRL_DATASET];
      refuse_calls <= forms_out && ctrl_reg[CTRL_SPROCKET] && ctrl_reg[CTRL_DATASET];
      low_supply_alarm <= low_paper && !ctrl_reg[CTRL_SPROCKET];
    end
  end

  property p_parity_even;
    @(posedge clk) disable iff (sys_rst)
      (tx_state_reg == TX_SEND && tx_from_kb_reg && ctrl_reg[CTRL_PARITY_FITTED]
       && ctrl_reg[CTRL_PARITY_EN]) |-> !(^tx_code_reg);
  endproperty
  a_parity_even: assert property (p_parity_even) else $error("odd parity sent");
  property p_level8_mark;
    @(posedge clk) disable iff (sys_rst)
      (tx_state_reg == TX_SEND && tx_from_kb_reg && !ctrl_reg[CTRL_PARITY_FITTED])
      |-> tx_code_reg[7];
  endproperty
  a_level8_mark: assert property (p_level8_mark) else $error("eighth level not mark");
  property p_break_open;
    @(posedge clk) disable iff (sys_rst) kb_break |=> !line_out;
  endproperty
  a_break_open: assert property (p_break_open) else $error("line closed in break");
  property p_cr_margin;
    @(posedge clk) disable iff (sys_rst) (pv && pc == C_CR) |=> (col_reg == 7'h00 && cr_pulse);
  endproperty
  a_cr_margin: assert property (p_cr_margin) else $error("return missed");
  property p_func_noprint;
    @(posedge clk) disable iff (sys_rst) (pv && is_func) |=> !print_strobe;
  endproperty
  a_func_noprint: assert property (p_func_noprint) else $error("function printed");
  property p_line_max;
    @(posedge clk) disable iff (sys_rst) col_reg <= 7'(LINE_LEN);
  endproperty
  a_line_max: assert property (p_line_max) else $error("column overrun");
  property p_bell_71;
    @(posedge clk) disable iff (sys_rst)
      (pv && is_print && col_reg == 7'(BELL_POS - 1) && ctrl_reg[CTRL_BELL_EN])
      |=> line_end_bell ##1 !line_end_bell;
  endproperty
  a_bell_71: assert property (p_bell_71) else $error("bell missed");
  property p_dc1_start;
    @(posedge clk) disable iff (sys_rst)
      (pv && pc == C_DC1 && ctrl_reg[CTRL_READER_AUTO]) |=> reader_run;
  endproperty
  a_dc1_start: assert property (p_dc1_start) else $error("reader not started");
  property p_forms_alarm;
    @(posedge clk) disable iff (sys_rst)
      (forms_out && ctrl_reg[CTRL_SPROCKET] && ctrl_reg[CTRL_DATASET])
      |=> (paper_alarm && refuse_calls);
  endproperty
  a_forms_alarm: assert property (p_forms_alarm) else $error("forms alarm missed");
endmodule
`default_nettype wire

// ==== tb/tch_far_station.sv ====
// Far station model: sends characters to the block and decodes its serial line.
// Assumes frames of one start space, 8 levels LSB first, then stop marks.
`timescale 1ns/10ps
`default_nettype none
module tch_far_station #(
  parameter int BC = 4
) (
  input wire logic clk, // Bench clock
  input wire logic line_out, // Serial line, 1 = mark
  output logic rx_valid, // Character strobe
  output logic [7:0] rx_code // Character code
);
  logic [7:0] got;
  int cnt = 0;
  initial begin
    rx_valid = 1'b0;
    rx_code = 8'h00;
  end
  // One strobed code, plus two fill codes after a function; the code lines show garbage once released
  task automatic send(input logic [7:0] c);
    @(posedge clk);
    rx_code <= c;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_code <= ~c;
    // Functions get two fill codes so the mechanism can finish
    if (c < 8'h20) begin
      send(8'h7F);
      send(8'h7F);
    end
  endtask
  // Sample each level near its middle, least significant first
  initial forever begin
    @(posedge clk);
    if (line_out === 1'b0) begin
      repeat (BC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BC) @(posedge clk);
        got[i] = line_out;
      end
      repeat (BC) @(posedge clk);
      cnt++;
    end
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the character handler, register access over AXI4-Lite.
// Assumes the far station model on the serial line and a 200 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import tch_pkg::*;
  localparam int BC = 4;
  logic clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, tape_holes, rx_code, feed_lines, fl;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic kb_key_down, kb_repeat, kb_break, kb_eot, ab_trigger, tape_valid, rx_valid, forms_out;
  logic low_paper, line_out, tape_ready, reader_run, print_strobe, cr_pulse, feed_pulse;
  logic space_pulse, line_end_bell, paper_alarm, refuse_calls, low_supply_alarm;
  logic [6:0] kb_code, print_glyph;
  int num_errors = 0, total_checks = 0, base = 0, n;
  int cnt[5] = '{0, 0, 0, 0, 0}, c0[5];
  tch_top #(.BIT_CYCLES(BC), .LINE_LEN(72)) u_dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .kb_key_down, .kb_code, .kb_repeat, .kb_break,
    .kb_eot, .ab_trigger, .tape_valid, .tape_holes, .rx_valid, .rx_code, .forms_out, .low_paper,
    .line_out, .tape_ready, .reader_run, .print_strobe, .print_glyph, .cr_pulse, .feed_pulse,
    .feed_lines, .space_pulse, .line_end_bell, .paper_alarm, .refuse_calls, .low_supply_alarm);
  tch_far_station #(.BC(BC)) u_far (.clk, .line_out, .rx_valid, .rx_code);
  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Printer pulse counters: print, space, return, feed, bell
  always @(posedge clk) begin
    cnt[0] <= cnt[0] + (print_strobe === 1'b1);
    cnt[1] <= cnt[1] + (space_pulse === 1'b1);
    cnt[2] <= cnt[2] + (cr_pulse === 1'b1);
    cnt[3] <= cnt[3] + (feed_pulse === 1'b1);
    cnt[4] <= cnt[4] + (line_end_bell === 1'b1);
    if (feed_pulse === 1'b1) fl <= feed_lines;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Bus write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Wait for k more frames on the line, then compare the last one
  task automatic frm(input int k, input logic [7:0] e);
    n = 0;
    while (u_far.cnt < base + k && n < 800) begin
      @(posedge clk);
      n++;
    end
    chk(32'(u_far.cnt - base), 32'(k));
    chk({24'h0, u_far.got}, {24'h0, e});
    base = u_far.cnt;
    repeat (8) @(posedge clk);
  endtask
  task automatic kf(input logic [31:0] ctrl, input logic [6:0] c, input logic [7:0] e);
    wr(CTRL_OFF, ctrl);
    @(posedge clk);
    kb_code <= c;
    kb_key_down <= 1'b1;
    @(posedge clk);
    kb_key_down <= 1'b0;
    frm(1, e);
  endtask
  task automatic rx(input logic [7:0] c);
    u_far.send(c);
    repeat (3) @(posedge clk);
  endtask
  task automatic col(input logic [6:0] e);
    rd(STATUS_OFF);
    chk({25'h0, d[6:0]}, {25'h0, e});
  endtask
  task automatic dl(input int i, input int e);
    chk(32'(cnt[i] - c0[i]), 32'(e));
  endtask
  // Main sequence
  initial begin
    {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tape_holes, kb_code} = '0;
    {kb_key_down, kb_repeat, kb_break, kb_eot, ab_trigger, tape_valid, forms_out, low_paper} = '0;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(CTRL_OFF);
    chk(d, 32'h7F3);
    rd(8'h20);
    chk({d[29:0], r}, 32'h2);
    wr(STATUS_OFF, 32'h0);
    chk(32'(r), 32'h2);
    $display("test registers done");
    kf(32'h7F3, 7'h43, 8'hC3);
    kf(32'h7F3, 7'h41, 8'h41);
    kf(32'h7F2, 7'h43, 8'h43);
    kf(32'h7F1, 7'h41, 8'hC1);
    wr(CTRL_OFF, 32'h7F3);
    $display("test keyboard done");
    rx(C_CR);
    c0 = cnt;
    rx(8'h41);
    dl(0, 1);
    chk(32'(print_glyph), 32'h41);
    rx(C_SP);
    dl(1, 1);
    col(2);
    rx(C_LF);
    chk(32'(fl), 32'h1);
    rx(C_NUL);
    dl(0, 1);
    col(2);
    rx(C_CR);
    dl(2, 1);
    col(0);
    c0 = cnt;
    repeat (70) rx(8'h58);
    dl(4, 0);
    rx(8'h58);
    dl(4, 1);
    rx(8'h58);
    dl(2, 1);
    dl(3, 1);
    chk(32'(fl), 32'h1);
    col(0);
    wr(CTRL_OFF, 32'h7EB);
    repeat (75) rx(8'h58);
    col(72);
    rx(C_LF);
    chk(32'(fl), 32'h2);
    rx(C_FF);
    chk(32'(fl), 32'h42);
    wr(CTRL_OFF, 32'h7F3);
    $display("test printer done");
    rx(C_DC1);
    chk(32'(reader_run), 32'h1);
    @(posedge clk);
    tape_holes <= 8'h5A;
    tape_valid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (tape_ready !== 1'b1 && n < 100);
    tape_valid <= 1'b0;
    frm(1, 8'h5A);
    chk(32'(print_glyph), 32'h5A);
    rx(C_DC3);
    chk(32'(reader_run), 32'h0);
    wr(AB_WRITE_OFF, 32'h041);
    wr(AB_WRITE_OFF, 32'h142);
    wr(AB_LEN_OFF, 32'h2);
    ab_trigger <= 1'b1;
    frm(2, 8'h42);
    ab_trigger <= 1'b0;
    kb_eot <= 1'b1;
    frm(1, 8'h84);
    kb_eot <= 1'b0;
    kb_code <= 7'h41;
    kb_key_down <= 1'b1;
    kb_repeat <= 1'b1;
    repeat (150) @(posedge clk);
    kb_key_down <= 1'b0;
    kb_repeat <= 1'b0;
    repeat (60) @(posedge clk);
    chk(32'(u_far.cnt - base >= 2), 32'h1);
    $display("test transmit done");
    forms_out <= 1'b1;
    repeat (3) @(posedge clk);
    chk({paper_alarm, refuse_calls}, 32'h3);
    forms_out <= 1'b0;
    wr(CTRL_OFF, 32'h5F3);
    low_paper <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(low_supply_alarm), 32'h1);
    kb_break <= 1'b1;
    repeat (3) @(posedge clk);
    n = 0;
    repeat (20) begin
      @(posedge clk);
      n += (line_out !== 1'b0);
    end
    chk(32'(n), 32'h0);
    kb_break <= 1'b0;
    $display("test alarms and break done");
    complete_run();
  end
  // Watchdog
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
